/* File: logic/scg_cfg.svh */
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SCG_OFF_RAM_LO     4'h0
`define SCG_OFF_RAM_HI     4'h1
`define SCG_OFF_ROM_TOP    4'h2
`define SCG_OFF_RELOC      4'h3
`define SCG_OFF_CONFIG     4'h4
`define SCG_OFF_STATUS     4'h5
`define SCG_OFF_WAITS      4'h6

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define SCG_CFG_HIGH_IO    0
`define SCG_CFG_ROM_EN     1
`define SCG_CFG_CLK_DIV    2
`define SCG_RST_CONFIG     8'h06
`define SCG_RST_RAM_LO     8'hff
`define SCG_RST_RAM_HI     8'h00
`define SCG_RST_ROM_TOP    8'h00
`define SCG_RST_RELOC      8'h00
`define SCG_RELOC_HI       7
`define SCG_RELOC_LO       6

// ----------------------------------------------------------------------------
// address map constants
// ----------------------------------------------------------------------------
`define SCG_PAGE_HI        19
`define SCG_PAGE_LO        12
`define SCG_ROM_END_PAGE   8'h08
`define SCG_PAGE_ZERO      8'h00
`define SCG_CELL_LO        8'hd8
`define SCG_CELL_HI        8'hf7
`define SCG_HIGH_ZERO      8'h00
`define SCG_WAIT_MAX       8'hff

`endif

/* File: logic/scg_pkg.sv */
package scg_pkg;

  typedef struct packed {
    logic [19:0] addr;
    logic        memory_request_n_n;
    logic        io_request_n_n;
    logic        m1_n;
    logic        chain_in;
    logic        wait_n;
  } scg_pins_s;

  typedef enum logic [1:0] {
    SCG_IDLE   = 2'b00,
    SCG_SAMPLE = 2'b01,
    SCG_DONE   = 2'b11
  } scg_cycle_e;

  typedef struct packed {
    logic io_sel;
    logic ram_sel;
    logic rom_sel;
  } scg_sel_s;

endpackage

/* File: logic/scg_sync.sv */
`timescale 1ns/1ps
module scg_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          CLK,
  input  wire logic          RESET,
  input  wire logic [W-1:0]  D,
  output logic      [W-1:0]  Q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  wire  [W-1:0] nxt_q;

  // a change counts once stages two and three agree
  assign nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      q_ff  <= RST;
    end else begin
      s1_ff <= D;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign Q = q_ff;

endmodule // scg_sync

/* File: logic/scg_glue.sv */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "scg_cfg.svh"
module scg_glue
  import scg_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [19:0] ADDR,
  input  wire logic        MEMORY_REQUEST_N,
  input  wire logic        IO_REQUEST_N,
  input  wire logic        FIRST_CYCLE_FLAG_N,
  output logic             IO_SPACE_SELECT_N,
  output logic             RAM_WINDOW_SELECT_N,
  output logic             ROM_WINDOW_SELECT_N,
  input  wire logic        CHAIN_ENABLE_IN,
  input  wire logic        ONCHIP_INT_SERVICE,
  output logic             CHAIN_ENABLE_OUT,
  output logic             SYSTEM_CLOCK_OUT,
  input  wire logic        SERIAL_WAIT_REQ,
  input  wire logic        WAIT_LINE_N,
  output logic             WAIT_DRIVE_N,
  output logic             WAIT_OE,
  input  wire logic        CYCLE_REQ,
  output logic             CYCLE_DONE
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  localparam scg_pins_s PINS_RST = '{addr: 20'h00000, memory_request_n_n: 1'b1, io_request_n_n: 1'b1,
                                     m1_n: 1'b1, chain_in: 1'b0, wait_n: 1'b1};

  scg_pins_s pins_raw;
  scg_pins_s pins;
  logic [$bits(scg_pins_s)-1:0] pins_q;

  assign pins_raw = '{addr: ADDR, memory_request_n_n: MEMORY_REQUEST_N, io_request_n_n: IO_REQUEST_N,
                      m1_n: FIRST_CYCLE_FLAG_N, chain_in: CHAIN_ENABLE_IN,
                      wait_n: WAIT_LINE_N};

  scg_sync #(
    .W   ($bits(scg_pins_s)),
    .RST (PINS_RST)
  ) u_pin_sync (
    .CLK   (CLK),
    .RESET (RESET),
    .D     (pins_raw),
    .Q     (pins_q)
  );

  assign pins = scg_pins_s'(pins_q);

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  logic [7:0]  ram_lower_bound_ff;
  logic [7:0]  ram_upper_bound_ff;
  logic [7:0]  rom_upper_boundary_ff;
  logic [7:0]  io_relocation_control_ff;
  logic [7:0]  config_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic [7:0]  wait_count_ff;

  wire         wr_ram_lo  = REG_WR && (REG_ADDR == `SCG_OFF_RAM_LO);
  wire         wr_ram_hi  = REG_WR && (REG_ADDR == `SCG_OFF_RAM_HI);
  wire         wr_rom_top = REG_WR && (REG_ADDR == `SCG_OFF_ROM_TOP);
  wire         wr_reloc   = REG_WR && (REG_ADDR == `SCG_OFF_RELOC);
  wire         wr_config  = REG_WR && (REG_ADDR == `SCG_OFF_CONFIG);

  wire         high_io_dec = config_ff[`SCG_CFG_HIGH_IO];
  wire         rom_enable  = config_ff[`SCG_CFG_ROM_EN];
  wire         clk_divide  = config_ff[`SCG_CFG_CLK_DIV];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ram_lower_bound_ff       <= `SCG_RST_RAM_LO;
      ram_upper_bound_ff       <= `SCG_RST_RAM_HI;
      rom_upper_boundary_ff    <= `SCG_RST_ROM_TOP;
      io_relocation_control_ff <= `SCG_RST_RELOC;
      config_ff                <= `SCG_RST_CONFIG;
    end else begin
      if (wr_ram_lo)  ram_lower_bound_ff       <= REG_WDATA;
      if (wr_ram_hi)  ram_upper_bound_ff       <= REG_WDATA;
      if (wr_rom_top) rom_upper_boundary_ff    <= REG_WDATA;
      if (wr_reloc)   io_relocation_control_ff <= REG_WDATA;
      if (wr_config)  config_ff                <= REG_WDATA;
    end
  end

  // --------------------------------------------------------------------------
  // i/o space decode
  // --------------------------------------------------------------------------
  wire [7:0]   io_lo      = pins.addr[7:0];
  wire [7:0]   io_hi      = pins.addr[15:8];
  // interrupt acknowledge drives both strobes low and is no i/o access
  wire         int_ack    = !pins.io_request_n_n && !pins.m1_n;
  wire         io_cycle   = !pins.io_request_n_n && !int_ack;
  wire         hi_nonzero = (io_hi != `SCG_HIGH_ZERO);
  // on-chip register block follows relocation
  wire         in_reg_blk = (io_lo[`SCG_RELOC_HI:`SCG_RELOC_LO] ==
                             io_relocation_control_ff[`SCG_RELOC_HI:`SCG_RELOC_LO]);
  // on-chip cell block, aligned to groups of eight
  wire         in_cell_blk = (io_lo >= `SCG_CELL_LO) && (io_lo <= `SCG_CELL_HI);
  wire         io_hit_low  = !in_cell_blk && (!in_reg_blk || hi_nonzero);
  wire         io_hit_full = hi_nonzero || (!in_reg_blk && !in_cell_blk);
  wire         io_hit      = io_cycle && (high_io_dec ? io_hit_full : io_hit_low);

  // --------------------------------------------------------------------------
  // memory windows
  // --------------------------------------------------------------------------
  wire [7:0]   mem_page  = pins.addr[`SCG_PAGE_HI:`SCG_PAGE_LO];
  wire         mem_cycle = !pins.memory_request_n_n;
  wire         ram_hit   = mem_cycle && (mem_page >= ram_lower_bound_ff) &&
                           (mem_page <= ram_upper_bound_ff);
  wire [7:0]   rom_base  = rom_enable ? `SCG_ROM_END_PAGE : `SCG_PAGE_ZERO;
  wire         rom_hit   = mem_cycle && (mem_page >= rom_base) &&
                           (mem_page <= rom_upper_boundary_ff);

  scg_sel_s    sel_ff;
  scg_sel_s    nxt_sel;

  assign nxt_sel = '{io_sel: io_hit, ram_sel: ram_hit, rom_sel: rom_hit};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sel_ff <= '0;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // --------------------------------------------------------------------------
  // select pins, registered active low
  // --------------------------------------------------------------------------
  logic        io_sel_n_ff;
  logic        ram_sel_n_ff;
  logic        rom_sel_n_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      io_sel_n_ff  <= 1'b1;
      ram_sel_n_ff <= 1'b1;
      rom_sel_n_ff <= 1'b1;
    end else begin
      io_sel_n_ff  <= !nxt_sel.io_sel;
      ram_sel_n_ff <= !nxt_sel.ram_sel;
      rom_sel_n_ff <= !nxt_sel.rom_sel;
    end
  end

  assign IO_SPACE_SELECT_N   = io_sel_n_ff;
  assign RAM_WINDOW_SELECT_N = ram_sel_n_ff;
  assign ROM_WINDOW_SELECT_N = rom_sel_n_ff;

  // --------------------------------------------------------------------------
  // interrupt daisy chain
  // --------------------------------------------------------------------------
  logic        chain_out_ff;
  // service level is internal to this clock, taken unsynchronised
  wire         nxt_chain_out = pins.chain_in && !ONCHIP_INT_SERVICE;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      chain_out_ff <= 1'b0;
    end else begin
      chain_out_ff <= nxt_chain_out;
    end
  end

  assign CHAIN_ENABLE_OUT = chain_out_ff;

  // --------------------------------------------------------------------------
  // system clock enable
  // --------------------------------------------------------------------------
  logic        sys_en_ff;
  // every cycle when undivided, every other cycle when divided
  wire         nxt_sys_en = clk_divide ? !sys_en_ff : 1'b1;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sys_en_ff <= 1'b0;
    end else begin
      sys_en_ff <= nxt_sys_en;
    end
  end

  assign SYSTEM_CLOCK_OUT = sys_en_ff;

  // --------------------------------------------------------------------------
  // shared wait line
  // --------------------------------------------------------------------------
  logic        wait_oe_ff;
  logic        wait_o_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wait_oe_ff <= 1'b0;
      wait_o_ff  <= 1'b0;
    end else begin
      wait_oe_ff <= SERIAL_WAIT_REQ;
      wait_o_ff  <= 1'b0;
    end
  end

  assign WAIT_DRIVE_N = wait_o_ff;
  assign WAIT_OE      = wait_oe_ff;

  // wired-or of the pin and our own request
  wire         wait_low = !pins.wait_n || SERIAL_WAIT_REQ;
  // the wait count holds at its top instead of wrapping
  wire         wait_sat = (wait_count_ff == `SCG_WAIT_MAX);

  // --------------------------------------------------------------------------
  // bus cycle completion
  // --------------------------------------------------------------------------
  scg_cycle_e  state_ff;
  scg_cycle_e  nxt_state;
  logic        done_ff;
  logic [7:0]  nxt_wait_count;

  always_comb begin
    nxt_state      = state_ff;
    nxt_wait_count = wait_count_ff;
    case (state_ff)
      SCG_IDLE: begin
        if (CYCLE_REQ) begin
          nxt_state      = SCG_SAMPLE;
          nxt_wait_count = 8'h00;
        end
      end
      SCG_SAMPLE: begin
        if (sys_en_ff) begin
          if (wait_low) begin
            if (!wait_sat) begin
              nxt_wait_count = wait_count_ff + 8'h01;
            end
          end else begin
            nxt_state = SCG_DONE;
          end
        end
      end
      SCG_DONE: begin
        nxt_state = SCG_IDLE;
      end
      default: begin
        nxt_state = SCG_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff      <= SCG_IDLE;
      done_ff       <= 1'b0;
      wait_count_ff <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      done_ff       <= (nxt_state == SCG_DONE);
      wait_count_ff <= nxt_wait_count;
    end
  end

  assign CYCLE_DONE = done_ff;

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  wire [7:0]   status_word = {2'b00, chain_out_ff, state_ff, sel_ff};

  always_comb begin
    nxt_rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        `SCG_OFF_RAM_LO:  nxt_rdata = ram_lower_bound_ff;
        `SCG_OFF_RAM_HI:  nxt_rdata = ram_upper_bound_ff;
        `SCG_OFF_ROM_TOP: nxt_rdata = rom_upper_boundary_ff;
        `SCG_OFF_RELOC:   nxt_rdata = io_relocation_control_ff;
        `SCG_OFF_CONFIG:  nxt_rdata = config_ff;
        `SCG_OFF_STATUS:  nxt_rdata = status_word;
        `SCG_OFF_WAITS:   nxt_rdata = wait_count_ff;
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;

endmodule // scg_glue

/* File: testbench/scg_glue_asserts.sv */
`timescale 1ns/1ps
module scg_glue_asserts
  import scg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MEMORY_REQUEST_N,
  input wire logic IO_REQUEST_N,
  input wire logic FIRST_CYCLE_FLAG_N,
  input wire logic IO_SPACE_SELECT_N,
  input wire logic RAM_WINDOW_SELECT_N,
  input wire logic ROM_WINDOW_SELECT_N,
  input wire logic CHAIN_ENABLE_IN,
  input wire logic ONCHIP_INT_SERVICE,
  input wire logic CHAIN_ENABLE_OUT,
  input wire logic SYSTEM_CLOCK_OUT,
  input wire logic SERIAL_WAIT_REQ,
  input wire logic WAIT_DRIVE_N,
  input wire logic WAIT_OE,
  input wire logic CYCLE_DONE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_reset_idle: assert property (
    $fell(RESET) |-> IO_SPACE_SELECT_N && RAM_WINDOW_SELECT_N && ROM_WINDOW_SELECT_N
      && !CHAIN_ENABLE_OUT && !SYSTEM_CLOCK_OUT && !WAIT_OE && !CYCLE_DONE)
    else $error("outputs active after reset");
  a_io_quiet: assert property (
    (IO_REQUEST_N || !FIRST_CYCLE_FLAG_N) [*6] |=> IO_SPACE_SELECT_N)
    else $error("io select without io request");
  a_mem_quiet: assert property (
    MEMORY_REQUEST_N [*6] |=> RAM_WINDOW_SELECT_N && ROM_WINDOW_SELECT_N)
    else $error("memory select without memory request");
  a_chain_service: assert property (
    ONCHIP_INT_SERVICE |=> !CHAIN_ENABLE_OUT)
    else $error("chain out high while servicing");
  a_chain_pin: assert property (
    !CHAIN_ENABLE_IN [*6] |=> !CHAIN_ENABLE_OUT)
    else $error("chain out high with chain in low");
  a_done_pulse: assert property (
    CYCLE_DONE |=> !CYCLE_DONE)
    else $error("cycle done longer than one cycle");
  a_wait_merge: assert property (
    !$past(RESET) && SERIAL_WAIT_REQ |=> WAIT_OE && !WAIT_DRIVE_N)
    else $error("serial wait not driven on wait line");
  a_wait_hold: assert property (
    SERIAL_WAIT_REQ [*3] |=> !CYCLE_DONE)
    else $error("cycle completed during wait");

  c_io_sel: cover property (!IO_SPACE_SELECT_N);
  c_ram_sel: cover property (!RAM_WINDOW_SELECT_N);
  c_done: cover property (CYCLE_DONE);
  c_rom_sel: cover property (!ROM_WINDOW_SELECT_N);
endmodule // scg_glue_asserts

bind scg_glue scg_glue_asserts u_chk (
  .CLK(CLK), .RESET(RESET), .MEMORY_REQUEST_N(MEMORY_REQUEST_N),
  .IO_REQUEST_N(IO_REQUEST_N), .FIRST_CYCLE_FLAG_N(FIRST_CYCLE_FLAG_N),
  .IO_SPACE_SELECT_N(IO_SPACE_SELECT_N), .RAM_WINDOW_SELECT_N(RAM_WINDOW_SELECT_N),
  .ROM_WINDOW_SELECT_N(ROM_WINDOW_SELECT_N), .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN),
  .ONCHIP_INT_SERVICE(ONCHIP_INT_SERVICE), .CHAIN_ENABLE_OUT(CHAIN_ENABLE_OUT),
  .SYSTEM_CLOCK_OUT(SYSTEM_CLOCK_OUT), .SERIAL_WAIT_REQ(SERIAL_WAIT_REQ),
  .WAIT_DRIVE_N(WAIT_DRIVE_N), .WAIT_OE(WAIT_OE), .CYCLE_DONE(CYCLE_DONE)
);

/* File: testbench/scg_wait_peer.sv */
`timescale 1ns/1ps
module scg_wait_peer
  import scg_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       START,
  input  wire logic [7:0] HOLD,
  output logic            PULL
);
  logic [7:0] left_ff = 8'h00;
  always_ff @(posedge CLK) begin
    if (START) begin
      left_ff <= HOLD;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
  // slow peripheral: open-drain pull on the wait line
  assign PULL = (left_ff != 8'h00);
endmodule // scg_wait_peer

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import scg_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  ra = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic [2:0]  req = 3'b111;
  logic        ch_in = 1'b0;
  logic        svc = 1'b0;
  logic        swr = 1'b0;
  logic        creq = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  hold = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  wait_k;
  logic        io_n, ram_n, rom_n, ch_out, sclk, wo, woe, done, pull;
  wire         wait_line = ~((woe & ~wo) | pull);
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [19:0] io_tab [20] = '{
    {3'h0,16'h0040,1'b0}, {3'h0,16'h00d7,1'b0}, {3'h0,16'h00d8,1'b1}, {3'h0,16'h00f7,1'b1},
    {3'h0,16'h00f8,1'b0}, {3'h0,16'h0000,1'b1}, {3'h0,16'h003f,1'b1}, {3'h0,16'h013f,1'b0},
    {3'h0,16'h01d8,1'b1}, {3'h4,16'h0000,1'b1}, {3'h4,16'h00d8,1'b1}, {3'h4,16'h0100,1'b0},
    {3'h4,16'h01d8,1'b0}, {3'h4,16'hffff,1'b0}, {3'h4,16'h0041,1'b0}, {3'h1,16'h0040,1'b1},
    {3'h1,16'h007f,1'b1}, {3'h1,16'h0000,1'b0}, {3'h1,16'h0080,1'b0}, {3'h1,16'h0140,1'b0}};
  logic [22:0] mem_tab [6] = '{{20'h07000,3'b111}, {20'h08000,3'b110}, {20'h0ffff,3'b110},
    {20'h10000,3'b101}, {20'h1ffff,3'b101}, {20'h20000,3'b111}};
  logic [11:0] reg_tab [6] = '{{4'h0,8'hff}, {4'h1,8'h00}, {4'h2,8'h00}, {4'h3,8'h00},
    {4'h4,8'h06}, {4'hf,8'h00}};

  always #25 clk = ~clk;

  scg_glue u_dut (
    .CLK(clk), .RESET(reset), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .ADDR(addr), .MEMORY_REQUEST_N(req[2]), .IO_REQUEST_N(req[1]),
    .FIRST_CYCLE_FLAG_N(req[0]), .IO_SPACE_SELECT_N(io_n), .RAM_WINDOW_SELECT_N(ram_n),
    .ROM_WINDOW_SELECT_N(rom_n), .CHAIN_ENABLE_IN(ch_in), .ONCHIP_INT_SERVICE(svc),
    .CHAIN_ENABLE_OUT(ch_out), .SYSTEM_CLOCK_OUT(sclk), .SERIAL_WAIT_REQ(swr),
    .WAIT_LINE_N(wait_line), .WAIT_DRIVE_N(wo), .WAIT_OE(woe), .CYCLE_REQ(creq),
    .CYCLE_DONE(done));
  scg_wait_peer u_peer (.CLK(clk), .START(go), .HOLD(hold), .PULL(pull));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
    @(posedge clk);
  endtask

  // pins settle through the synchronisers before the selects are looked at
  task automatic probe(input logic [19:0] a, input logic [2:0] r, input logic [2:0] e);
    addr <= a;
    req <= r;
    repeat (7) @(posedge clk);
    #1 check({5'h00, io_n, ram_n, rom_n}, {5'h00, e});
    @(posedge clk);
  endtask

  task automatic clk_count(input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    repeat (4) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      #1 c = c + {7'h00, sclk};
    end
    check(c, e);
    @(posedge clk);
  endtask

  task automatic chain(input logic i, input logic s, input logic e);
    ch_in <= i;
    svc <= s;
    repeat (7) @(posedge clk);
    #1 check({7'h00, ch_out}, {7'h00, e});
    @(posedge clk);
  endtask

  // bounded wait for the completion pulse; running out ends the run
  task automatic wait_done(output logic [7:0] k);
    k = 8'h00;
    while (done !== 1'b1 && k < 8'd60) begin
      @(posedge clk);
      #1 k = k + 8'h01;
    end
    check({7'h00, done}, 8'h01);
    if (done !== 1'b1) end_of_test;
  endtask

  task automatic bus_cycle(input logic [7:0] h);
    logic [7:0] k;
    hold <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // peer pulls early enough to pass the synchroniser before the sample point
    repeat (3) @(posedge clk);
    creq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    wait_done(k);
    check({7'h00, k > h}, 8'h01);
    @(posedge clk);
    rreg(4'h6, h);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wreg(4'hf, 8'h5a);
    foreach (reg_tab[i]) rreg(reg_tab[i][11:8], reg_tab[i][7:0]);
    foreach (io_tab[i]) begin
      wreg(4'h4, {7'h03, io_tab[i][19]});
      wreg(4'h3, {io_tab[i][18:17], 6'h00});
      probe({4'h0, io_tab[i][16:1]}, 3'b101, {io_tab[i][0], 2'b11});
    end
    probe(20'h00100, 3'b100, 3'b111);
    wreg(4'h3, 8'h00);
    wreg(4'h4, 8'h06);
    wreg(4'h0, 8'h10);
    wreg(4'h1, 8'h1f);
    wreg(4'h2, 8'h0f);
    rreg(4'h1, 8'h1f);
    foreach (mem_tab[i]) probe(mem_tab[i][22:3], 3'b011, mem_tab[i][2:0]);
    probe(20'h10000, 3'b111, 3'b111);
    wreg(4'h4, 8'h04);
    probe(20'h00000, 3'b011, 3'b110);
    clk_count(8'h04);
    wreg(4'h4, 8'h02);
    clk_count(8'h08);
    chain(1'b1, 1'b0, 1'b1);
    chain(1'b1, 1'b1, 1'b0);
    chain(1'b0, 1'b0, 1'b0);
    swr <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check({6'h00, woe, wait_line}, 8'h02);
    @(posedge clk);
    creq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1 check({7'h00, done}, 8'h00);
    end
    @(posedge clk);
    swr <= 1'b0;
    wait_done(wait_k);
    @(posedge clk);
    bus_cycle(8'h00);
    bus_cycle(8'h0c);
    end_of_test;
  end
endmodule // tb_top
